// ===== port_mac_stats.sv
/*
 * Port 1 MAC statistics counters, transmit gap timer, receive gap,
 * length checks and MII loopback, with their register port.
 * Assumes frame events arrive as one-cycle pulses synchronous to clk
 * with their qualifiers valid in the same cycle.
 */
//
// Overview of operation
// - count every received frame, good or bad
// - count received broadcast frames, good or bad
// - count received multicast frames, good or bad
// - count received unicast frames
// - count received frames failing the FCS
// - count received frames with alignment error
// - count received long or short frames together
// - count received frames with PHY error
// - count every transmitted frame
// - count transmitted broadcast frames
// - count transmitted multicast frames
// - count transmitted unicast frames
// - count frames dropped for full FIFO
// - flooded frame counts only if both full
// - count frames dropped by address filter
// - count received frames with gap error
// - transmit gap is (setting+1) octet times
// - loopback bit 0 loops MII toward PHY
// - counters read-only and zero after reset
// - short receive gap drops frame, flags error
// - frame above maximum length is long
// - frame below minimum length is short
`timescale 1ns/1ps
`default_nettype none

module port_mac_stats #(
   parameter int data_width = 32, // register data width
   parameter int len_width = 16 // frame length width
) (
   input wire logic clk, // core clock, 125 MHz
   input wire logic rst_b, // async reset, active low
   input wire logic [7:0] reg_addr, // register index
   input wire logic reg_rd, // read strobe
   input wire logic reg_wr, // write strobe
   input wire logic [31:0] reg_wdata, // write data
   output logic [31:0] reg_rdata, // read data
   output logic reg_rvalid, // read data valid pulse
   input wire logic rx_start, // receive frame start pulse
   input wire logic rx_done, // receive frame end pulse
   input wire logic rx_bcast, // frame is broadcast
   input wire logic rx_mcast, // frame is multicast
   input wire logic rx_fcs_err, // FCS check failed
   input wire logic rx_align_err, // not whole octets
   input wire logic rx_phy_err, // PHY signalled error
   input wire logic [15:0] rx_len, // frame length in bytes
   input wire logic rx_filtered, // dropped by address filter
   input wire logic rx_dest_host, // destined to host FIFO
   input wire logic rx_dest_port, // destined to other port
   input wire logic host_fifo_full, // host FIFO full
   input wire logic port_fifo_full, // other port FIFO full
   input wire logic tx_done, // transmit frame end pulse
   input wire logic tx_bcast, // transmitted broadcast
   input wire logic tx_mcast, // transmitted multicast
   output logic tx_gap_hold, // transmitter must stay idle
   output logic rx_gap_error_flag, // gap error pulse
   output logic rx_frame_drop, // frame dropped for short gap
   output logic rx_long_frame, // long frame pulse
   output logic rx_short_frame, // short frame pulse
   input wire logic [3:0] mac_txd, // MAC transmit nibble
   input wire logic mac_tx_en, // MAC transmit enable
   input wire logic [3:0] phy_rxd, // PHY receive nibble
   input wire logic phy_rx_dv, // PHY receive valid
   output logic [3:0] phy_txd, // nibble toward PHY
   output logic phy_tx_en, // enable toward PHY
   output logic [3:0] mac_rxd, // nibble toward MAC
   output logic mac_rx_dv, // valid toward MAC
   output logic mac_loopback_enable // loopback state
);

   // counters and length compares are fixed-width; refuse other sizes at elaboration
   if (data_width != 32 || len_width != 16) begin : g_param_check
      $error("port_mac_stats supports only 32-bit data and 16-bit lengths");
   end

   logic [31:0] counters [port_mac_stats_pkg::num_counters];
   logic [port_mac_stats_pkg::num_counters-1:0] events;
   logic [7:0] tx_gap_setting;
   logic [5:0] rx_gap_min;
   logic [15:0] rx_max_len;
   logic [15:0] rx_min_len;
   logic rx_gap_bad;
   logic [6:0] rx_gap_octets;
   logic [6:0] rx_div;
   logic [6:0] tx_div;
   logic [8:0] tx_octets_left;
   logic next_drop_full;
   logic next_long;
   logic next_short;

   function automatic logic is_counter(input logic [7:0] addr);
      return addr >= port_mac_stats_pkg::counter_base &&
             addr < port_mac_stats_pkg::counter_base + 8'(port_mac_stats_pkg::num_counters);
   endfunction

   assign next_long = rx_len > rx_max_len;
   assign next_short = rx_len < rx_min_len;

   // flooded frame dropped only when every destination full
   always_comb begin
      next_drop_full = (rx_dest_host || rx_dest_port) &&
                       (!rx_dest_host || host_fifo_full) &&
                       (!rx_dest_port || port_fifo_full);
   end

   always_comb begin
      events = '0;
      if (rx_done) begin
         events[port_mac_stats_pkg::ev_rx_total] = 1'b1;
         events[port_mac_stats_pkg::ev_rx_bcast] = rx_bcast;
         events[port_mac_stats_pkg::ev_rx_mcast] = rx_mcast && !rx_bcast;
         events[port_mac_stats_pkg::ev_rx_ucast] = !rx_mcast && !rx_bcast;
         events[port_mac_stats_pkg::ev_rx_fcs] = rx_fcs_err;
         events[port_mac_stats_pkg::ev_rx_align] = rx_align_err;
         events[port_mac_stats_pkg::ev_rx_len] = next_long || next_short;
         events[port_mac_stats_pkg::ev_rx_phy] = rx_phy_err;
         events[port_mac_stats_pkg::ev_drop_full] = next_drop_full;
         events[port_mac_stats_pkg::ev_drop_filt] = rx_filtered;
         events[port_mac_stats_pkg::ev_gap_err] = rx_gap_bad;
      end
      if (tx_done) begin
         events[port_mac_stats_pkg::ev_tx_total] = 1'b1;
         events[port_mac_stats_pkg::ev_tx_bcast] = tx_bcast;
         events[port_mac_stats_pkg::ev_tx_mcast] = tx_mcast && !tx_bcast;
         events[port_mac_stats_pkg::ev_tx_ucast] = !tx_mcast && !tx_bcast;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < port_mac_stats_pkg::num_counters; gi++) begin : g_cnt
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               counters[gi] <= port_mac_stats_pkg::counter_reset;
            end else if (events[gi]) begin
               counters[gi] <= counters[gi] + 32'h0000_0001;
            end
         end
      end
   endgenerate

   // control registers; counters ignore writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_gap_setting <= port_mac_stats_pkg::tx_gap_reset;
         mac_loopback_enable <= port_mac_stats_pkg::loopback_reset;
         rx_gap_min <= port_mac_stats_pkg::rx_gap_reset;
         rx_max_len <= port_mac_stats_pkg::max_len_reset;
         rx_min_len <= port_mac_stats_pkg::min_len_reset;
      end else if (reg_wr) begin
         if (reg_addr == port_mac_stats_pkg::port1_tx_gap_setting) begin
            tx_gap_setting <= reg_wdata[7:0];
         end else if (reg_addr == port_mac_stats_pkg::port1_mac_loopback_control) begin
            mac_loopback_enable <= reg_wdata[port_mac_stats_pkg::loopback_bit];
         end else if (reg_addr == port_mac_stats_pkg::port1_rx_gap_minimum) begin
            rx_gap_min <= reg_wdata[5:0];
         end else if (reg_addr == port_mac_stats_pkg::port1_rx_max_len) begin
            rx_max_len <= reg_wdata[15:0];
         end else if (reg_addr == port_mac_stats_pkg::port1_rx_min_len) begin
            rx_min_len <= reg_wdata[15:0];
         end
      end
   end

   // read port, one cycle latency; unmapped reads return zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0000_0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            if (is_counter(reg_addr)) begin
               reg_rdata <= counters[4'(reg_addr - port_mac_stats_pkg::counter_base)];
            end else if (reg_addr == port_mac_stats_pkg::port1_tx_gap_setting) begin
               reg_rdata <= {24'h00_0000, tx_gap_setting};
            end else if (reg_addr == port_mac_stats_pkg::port1_mac_loopback_control) begin
               reg_rdata <= {31'h0000_0000, mac_loopback_enable};
            end else if (reg_addr == port_mac_stats_pkg::port1_rx_gap_minimum) begin
               reg_rdata <= {26'h000_0000, rx_gap_min};
            end else if (reg_addr == port_mac_stats_pkg::port1_rx_max_len) begin
               reg_rdata <= {16'h0000, rx_max_len};
            end else if (reg_addr == port_mac_stats_pkg::port1_rx_min_len) begin
               reg_rdata <= {16'h0000, rx_min_len};
            end else begin
               reg_rdata <= 32'h0000_0000;
            end
         end
      end
   end

   // receive gap measured in octet times since the last frame end;
   // saturates above the largest setting so idle lines never flag
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_div <= 7'h00;
         rx_gap_octets <= 7'h7F;
      end else if (rx_done) begin
         rx_div <= 7'h00;
         rx_gap_octets <= 7'h00;
      end else if (rx_div == port_mac_stats_pkg::octet_last) begin
         rx_div <= 7'h00;
         if (rx_gap_octets != 7'h7F) begin
            rx_gap_octets <= rx_gap_octets + 7'h01;
         end
      end else begin
         rx_div <= rx_div + 7'h01;
      end
   end

   // gap not above the minimum marks the frame bad
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_gap_bad <= 1'b0;
      end else if (rx_start) begin
         rx_gap_bad <= rx_gap_octets <= {1'b0, rx_gap_min};
      end else if (rx_done) begin
         rx_gap_bad <= 1'b0;
      end
   end

   // frame-end indications
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_gap_error_flag <= 1'b0;
         rx_frame_drop <= 1'b0;
         rx_long_frame <= 1'b0;
         rx_short_frame <= 1'b0;
      end else begin
         // drop and flag on frame end
         rx_gap_error_flag <= rx_done && rx_gap_bad;
         rx_frame_drop <= rx_done && rx_gap_bad;
         rx_long_frame <= rx_done && next_long;
         rx_short_frame <= rx_done && next_short;
      end
   end

   // hold off transmit for (setting+1) octet times after a frame
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_div <= 7'h00;
         tx_octets_left <= 9'h000;
         tx_gap_hold <= 1'b0;
      end else if (tx_done) begin
         tx_div <= 7'h00;
         tx_octets_left <= {1'b0, tx_gap_setting} + 9'h001;
         tx_gap_hold <= 1'b1;
      end else if (tx_gap_hold) begin
         if (tx_div == port_mac_stats_pkg::octet_last) begin
            tx_div <= 7'h00;
            tx_octets_left <= tx_octets_left - 9'h001;
            if (tx_octets_left == 9'h001) begin
               tx_gap_hold <= 1'b0;
            end
         end else begin
            tx_div <= tx_div + 7'h01;
         end
      end
   end

   // loopback returns PHY receive traffic to the PHY
   // the MAC still sees receive data but its transmit is blocked
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phy_txd <= 4'h0;
         phy_tx_en <= 1'b0;
         mac_rxd <= 4'h0;
         mac_rx_dv <= 1'b0;
      end else begin
         mac_rxd <= phy_rxd;
         mac_rx_dv <= phy_rx_dv;
         if (mac_loopback_enable) begin
            phy_txd <= phy_rxd;
            phy_tx_en <= phy_rx_dv;
         end else begin
            phy_txd <= mac_txd;
            phy_tx_en <= mac_tx_en;
         end
      end
   end

endmodule // port_mac_stats

`default_nettype wire

// ===== port_mac_stats_pkg.sv
/*
 * Constants for the port 1 MAC statistics and transmit gap block:
 * register indexes, reset values, field positions and octet timing.
 * Assumes a 125 MHz core clock and a 10 Mb/s line.
 */
package port_mac_stats_pkg;
   // register indexes as seen on the register port
   localparam logic [7:0] port1_rx_total_frames = 8'hA0;
   localparam logic [7:0] port1_rx_broadcast_frames = 8'hA1;
   localparam logic [7:0] port1_rx_multicast_frames = 8'hA2;
   localparam logic [7:0] port1_rx_unicast_frames = 8'hA3;
   localparam logic [7:0] port1_rx_fcs_error_frames = 8'hA4;
   localparam logic [7:0] port1_rx_alignment_errors = 8'hA5;
   localparam logic [7:0] port1_rx_length_errors = 8'hA6;
   localparam logic [7:0] port1_rx_phy_errors = 8'hA7;
   localparam logic [7:0] port1_tx_total_frames = 8'hA8;
   localparam logic [7:0] port1_tx_broadcast_frames = 8'hA9;
   localparam logic [7:0] port1_tx_multicast_frames = 8'hAA;
   localparam logic [7:0] port1_tx_unicast_frames = 8'hAB;
   localparam logic [7:0] port1_rx_dropped_fifo_full = 8'hAC;
   localparam logic [7:0] port1_rx_dropped_by_filter = 8'hAD;
   localparam logic [7:0] port1_rx_gap_error_frames = 8'hAE;
   localparam logic [7:0] port1_tx_gap_setting = 8'hB0;
   localparam logic [7:0] port1_mac_loopback_control = 8'hB3;
   localparam logic [7:0] port1_rx_gap_minimum = 8'hB5;
   localparam logic [7:0] port1_rx_max_len = 8'hB6;
   localparam logic [7:0] port1_rx_min_len = 8'hB7;

   localparam int num_counters = 15;
   localparam logic [7:0] counter_base = port1_rx_total_frames;

   // counter slots, in register order
   localparam int ev_rx_total = 0;
   localparam int ev_rx_bcast = 1;
   localparam int ev_rx_mcast = 2;
   localparam int ev_rx_ucast = 3;
   localparam int ev_rx_fcs = 4;
   localparam int ev_rx_align = 5;
   localparam int ev_rx_len = 6;
   localparam int ev_rx_phy = 7;
   localparam int ev_tx_total = 8;
   localparam int ev_tx_bcast = 9;
   localparam int ev_tx_mcast = 10;
   localparam int ev_tx_ucast = 11;
   localparam int ev_drop_full = 12;
   localparam int ev_drop_filt = 13;
   localparam int ev_gap_err = 14;

   // reset values and field positions
   localparam logic [31:0] counter_reset = 32'h0000_0000;
   localparam logic [7:0] tx_gap_reset = 8'h0B;
   localparam int loopback_bit = 0;
   localparam logic loopback_reset = 1'b0;
   localparam logic [5:0] rx_gap_reset = 6'h0A;
   localparam logic [15:0] max_len_reset = 16'h0618;
   localparam logic [15:0] min_len_reset = 16'h0040;

   // one gap unit is eight bit times at 10 Mb/s
   localparam int clk_mhz = 125;
   localparam int octet_time_ns = 800;
   localparam int octet_cycles = (octet_time_ns * clk_mhz) / 1000;
   localparam logic [6:0] octet_last = 7'(octet_cycles - 1);
endpackage : port_mac_stats_pkg

// ===== port_mac_stats_properties.sv
/* Checker for port_mac_stats: timing relations at its ports.
   Assumes the length limits stay at their reset values; bound from the bench. */
`timescale 1ns/1ps
`default_nettype none
module port_mac_stats_properties (
   input wire logic clk, // core clock
   input wire logic rst_b, // reset, active low
   input wire logic [7:0] reg_addr, // register index
   input wire logic reg_rd, // read strobe
   input wire logic reg_wr, // write strobe
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_rvalid, // read valid
   input wire logic rx_done, // rx frame end
   input wire logic [15:0] rx_len, // rx length
   input wire logic tx_done, // tx frame end
   input wire logic tx_gap_hold, // tx idle
   input wire logic rx_gap_error_flag, // gap error
   input wire logic rx_frame_drop, // gap drop
   input wire logic rx_long_frame, // long pulse
   input wire logic rx_short_frame, // short pulse
   input wire logic [3:0] mac_txd, // mac nibble
   input wire logic [3:0] phy_rxd, // phy nibble
   input wire logic [3:0] phy_txd, // toward phy
   input wire logic [3:0] mac_rxd, // toward mac
   input wire logic mac_loopback_enable // loopback
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [7:0] gap;
   int run;
   // shadow of the gap setting, so the hold length can be judged
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) gap <= port_mac_stats_pkg::tx_gap_reset;
      else if (reg_wr && reg_addr == port_mac_stats_pkg::port1_tx_gap_setting) gap <= reg_wdata[7:0];
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) run <= 0;
      else if (tx_done) run <= 0;
      else if (tx_gap_hold) run <= run + 1;
   end
   rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read got no valid");
   rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray valid");
   short_frame_a: assert property (rx_done && rx_len < 16'h0040 |=> rx_short_frame) else $error("no short");
   long_frame_a: assert property (rx_done && rx_len > 16'h0618 |=> rx_long_frame) else $error("no long");
   length_cause_a: assert property (rx_long_frame || rx_short_frame |-> $past(rx_done)
      && ($past(rx_len) > 16'h0618 || $past(rx_len) < 16'h0040)) else $error("stray length flag");
   gap_flag_a: assert property (rx_gap_error_flag |-> rx_frame_drop && $past(rx_done)) else $error("gap flag");
   hold_start_a: assert property (tx_done |=> tx_gap_hold) else $error("no tx gap");
   hold_length_a: assert property ($fell(tx_gap_hold) |-> run == (int'(gap) + 1) * 100)
      else $error("tx gap length");
   loop_write_a: assert property (reg_wr && reg_addr == port_mac_stats_pkg::port1_mac_loopback_control
      |=> mac_loopback_enable == $past(reg_wdata[0])) else $error("loop bit");
   loop_path_a: assert property (mac_loopback_enable && $past(mac_loopback_enable)
      |-> phy_txd == $past(phy_rxd)) else $error("loop path");
   normal_path_a: assert property (!mac_loopback_enable && !$past(mac_loopback_enable) && $past(rst_b)
      |-> phy_txd == $past(mac_txd)) else $error("normal path");
   rx_copy_a: assert property ($past(rst_b) |-> mac_rxd == $past(phy_rxd)) else $error("rx copy");
   cover property (rx_short_frame);
   cover property (rx_gap_error_flag);
   cover property ($fell(tx_gap_hold));
   cover property (mac_loopback_enable);
endmodule // port_mac_stats_properties
`default_nettype wire

// ===== port_mac_frame_source.sv
/* Far-side model: frame events of the MAC path and MII nibbles.
   Assumes the bench calls its tasks and wires it by name. */
`timescale 1ns/1ps
`default_nettype none
module port_mac_frame_source (
   input wire logic clk, // core clock
   input wire logic rst_b, // reset, active low
   output logic rx_start, // frame start
   output logic rx_done, // frame end
   output logic rx_bcast, // broadcast
   output logic rx_mcast, // multicast
   output logic rx_fcs_err, // fcs failed
   output logic rx_align_err, // odd bits
   output logic rx_phy_err, // phy error
   output logic [15:0] rx_len, // bytes
   output logic rx_filtered, // filtered
   output logic rx_dest_host, // to host
   output logic rx_dest_port, // to other port
   output logic host_fifo_full, // host full
   output logic port_fifo_full, // port full
   output logic tx_done, // tx end
   output logic tx_bcast, // tx broadcast
   output logic tx_mcast, // tx multicast
   output logic [3:0] mac_txd, // mac nibble
   output logic mac_tx_en, // mac enable
   output logic [3:0] phy_rxd, // phy nibble
   output logic phy_rx_dv // phy valid
);
   initial begin
      {rx_start, rx_done, tx_done, tx_bcast, tx_mcast} = 5'b00000;
      {port_fifo_full, host_fifo_full, rx_dest_port, rx_dest_host, rx_filtered} = 5'b00000;
      {rx_phy_err, rx_align_err, rx_fcs_err, rx_mcast, rx_bcast} = 5'b00000;
      rx_len = 16'h0000;
   end
   // nibbles change every cycle so a stale copy shows at once
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mac_txd <= 4'h0;
         phy_rxd <= 4'h9;
      end else begin
         mac_txd <= mac_txd + 4'h1;
         phy_rxd <= phy_rxd + 4'h7;
      end
   end
   assign mac_tx_en = mac_txd[1];
   assign phy_rx_dv = phy_rxd[2];
   task automatic rx_frame(input logic [9:0] f, input logic [15:0] n, input int idle);
      repeat (idle) @(posedge clk);
      rx_start <= 1'b1;
      @(posedge clk);
      rx_start <= 1'b0;
      @(posedge clk);
      {port_fifo_full, host_fifo_full, rx_dest_port, rx_dest_host, rx_filtered,
         rx_phy_err, rx_align_err, rx_fcs_err, rx_mcast, rx_bcast} <= f;
      rx_len <= n;
      rx_done <= 1'b1;
      @(posedge clk);
      // qualifiers mean nothing past the end pulse: show their inverse
      {port_fifo_full, host_fifo_full, rx_dest_port, rx_dest_host, rx_filtered,
         rx_phy_err, rx_align_err, rx_fcs_err, rx_mcast, rx_bcast} <= ~f;
      rx_len <= ~n;
      rx_done <= 1'b0;
   endtask
   task automatic tx_frame(input logic [1:0] t);
      @(posedge clk);
      {tx_mcast, tx_bcast} <= t;
      tx_done <= 1'b1;
      @(posedge clk);
      {tx_mcast, tx_bcast} <= ~t;
      tx_done <= 1'b0;
   endtask
endmodule // port_mac_frame_source
`default_nettype wire

// ===== port_mac_stats_tb.sv
/* Self-checking bench for port_mac_stats with the far-side model.
   Assumes the design package is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module port_mac_stats_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_rd, reg_wr, reg_rvalid, rx_start, rx_done, rx_bcast, rx_mcast, rx_fcs_err, rx_align_err;
   logic rx_phy_err, rx_filtered, rx_dest_host, rx_dest_port, host_fifo_full, port_fifo_full, tx_done;
   logic tx_bcast, tx_mcast, tx_gap_hold, rx_gap_error_flag, rx_frame_drop, rx_long_frame, rx_short_frame;
   logic mac_tx_en, phy_rx_dv, phy_tx_en, mac_rx_dv, mac_loopback_enable;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] rx_len;
   logic [3:0] mac_txd, phy_rxd, phy_txd, mac_rxd;
   logic [31:0] expv [15] = '{default: 32'h0000_0000};
   int err_count = 0;
   int tests_run = 0;
   port_mac_stats dut_u (.*);
   port_mac_frame_source far_u (.*);
   always #4 clk = ~clk;
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
      tests_run++;
      if (got !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check("read valid", 32'h1, {31'h0, reg_rvalid});
      check($sformatf("register %h", a), e, reg_rdata);
   endtask
   task automatic check_counters();
      for (int i = 0; i < port_mac_stats_pkg::num_counters; i++) begin
         expect_reg(port_mac_stats_pkg::counter_base + 8'(i), expv[i]);
      end
   endtask
   task automatic hold_len(input int e);
      int n;
      n = 0;
      #1;
      while (tx_gap_hold === 1'b1 && n < 30000) begin
         n++;
         @(posedge clk);
         #1;
      end
      check("tx gap cycles", 32'(e), 32'(n));
   endtask
   task automatic rx(input logic [9:0] f, input logic [15:0] n);
      far_u.rx_frame(f, n, 1200);
      expv[0]++;
      if (f[0]) expv[1]++;
      else if (f[1]) expv[2]++;
      else expv[3]++;
      expv[4] += 32'(f[2]);
      expv[5] += 32'(f[3]);
      expv[7] += 32'(f[4]);
      expv[13] += 32'(f[5]);
      if (n > port_mac_stats_pkg::max_len_reset || n < port_mac_stats_pkg::min_len_reset) expv[6]++;
      // a frame with several destinations is lost only if all are full
      if ((f[6] | f[7]) && (!f[6] || f[8]) && (!f[7] || f[9])) expv[12]++;
   endtask
   task automatic t_reset_values();
      check_counters();
      expect_reg(port_mac_stats_pkg::port1_tx_gap_setting, 32'h0000_000B);
      expect_reg(port_mac_stats_pkg::port1_mac_loopback_control, 32'h0000_0000);
      expect_reg(8'hB1, 32'h0000_0000);
      expect_reg(port_mac_stats_pkg::port1_rx_gap_minimum, 32'h0000_000A);
      expect_reg(port_mac_stats_pkg::port1_rx_max_len, 32'h0000_0618);
      expect_reg(port_mac_stats_pkg::port1_rx_min_len, 32'h0000_0040);
      $display("test reset values done");
   endtask
   task automatic t_rx_counts();
      logic [9:0] f [10] = '{10'h000, 10'h005, 10'h00A, 10'h013, 10'h000, 10'h020, 10'h1C0, 10'h3C0, 10'h140, 10'h080};
      logic [15:0] n [10] = '{16'd100, 16'h0040, 16'h0618, 16'h0619, 16'h003F, 16'd100, 16'd80, 16'd80, 16'd80, 16'd80};
      for (int i = 0; i < 10; i++) rx(f[i], n[i]);
      check_counters();
      $display("test receive counts done");
   endtask
   task automatic t_read_only();
      reg_write(port_mac_stats_pkg::port1_rx_total_frames, 32'hFFFF_FFFF);
      reg_write(port_mac_stats_pkg::port1_rx_gap_error_frames, 32'h1234_5678);
      reg_write(8'hB1, 32'h0000_5555);
      check_counters();
      expect_reg(8'hB1, 32'h0000_0000);
      $display("test read only done");
   endtask
   task automatic t_tx();
      far_u.tx_frame(2'b01);
      far_u.tx_frame(2'b10);
      far_u.tx_frame(2'b00);
      far_u.tx_frame(2'b11);
      hold_len((int'(port_mac_stats_pkg::tx_gap_reset) + 1) * 100);
      expv[8] += 32'h4;
      expv[9] += 32'h2;
      expv[10]++;
      expv[11]++;
      reg_write(port_mac_stats_pkg::port1_tx_gap_setting, 32'h0000_0000);
      far_u.tx_frame(2'b00);
      hold_len(100);
      reg_write(port_mac_stats_pkg::port1_tx_gap_setting, 32'hFFFF_FF02);
      expect_reg(port_mac_stats_pkg::port1_tx_gap_setting, 32'h0000_0002);
      far_u.tx_frame(2'b00);
      hold_len(300);
      expv[8] += 32'h2;
      expv[11] += 32'h2;
      check_counters();
      $display("test transmit done");
   endtask
   // inputs read before the edge's updates land; outputs one cycle behind them
   task automatic mii_check(input string what, input logic lb);
      logic [4:0] rx_in;
      logic [4:0] tx_in;
      @(posedge clk);
      rx_in = {phy_rx_dv, phy_rxd};
      tx_in = {mac_tx_en, mac_txd};
      #1;
      check(what, 32'(lb ? rx_in : tx_in), 32'({phy_tx_en, phy_txd}));
      check("mac receive copy", 32'(rx_in), 32'({mac_rx_dv, mac_rxd}));
   endtask
   task automatic t_loop();
      reg_write(port_mac_stats_pkg::port1_mac_loopback_control, 32'h0000_0001);
      expect_reg(port_mac_stats_pkg::port1_mac_loopback_control, 32'h0000_0001);
      repeat (20) @(posedge clk);
      mii_check("loop path", 1'b1);
      reg_write(port_mac_stats_pkg::port1_mac_loopback_control, 32'hFFFF_FFFE);
      expect_reg(port_mac_stats_pkg::port1_mac_loopback_control, 32'h0000_0000);
      mii_check("normal path", 1'b0);
      $display("test loopback done");
   endtask
   task automatic t_gap_err();
      // gap is measured from the previous frame end, so one must come first
      rx(10'h000, 16'd100);
      far_u.rx_frame(10'h000, 16'd100, 300);
      #1;
      check("gap flag", 32'h1, {31'h0, rx_gap_error_flag});
      check("gap drop", 32'h1, {31'h0, rx_frame_drop});
      expect_reg(port_mac_stats_pkg::port1_rx_gap_error_frames, 32'h0000_0001);
      $display("test gap error done");
   endtask
   initial begin
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      t_reset_values();
      t_rx_counts();
      t_read_only();
      t_tx();
      t_loop();
      t_gap_err();
      results();
   end
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      $display("watchdog expired");
      results();
   end
endmodule // port_mac_stats_tb
bind port_mac_stats port_mac_stats_properties props_u (.*);
`default_nettype wire
